// >>> rtl/srw_map.svh
// Register indices, reset values and timing counts of the stop recovery and watchdog block.
`ifndef SRW_MAP_SVH
`define SRW_MAP_SVH

// Register indices; the APB byte address is four times the index.
`define SRW_IDX_SMR        8'h0B
`define SRW_IDX_STOP_WAKE_CONFIG_SECOND       8'h0D
`define SRW_IDX_WATCHDOG_MODE_CONFIG      8'h0F

// Reset values of the configuration registers.
`define SRW_SMR_RST        8'h20
`define SRW_STOP_WAKE_CONFIG_SECOND_RST       8'h00
`define SRW_WATCHDOG_MODE_CONFIG_RST      8'h00

// Stop recovery source codes of the first recovery register.
`define SRW_SRC_NONE       3'h0
`define SRW_SRC_P31        3'h2
`define SRW_SRC_P32        3'h3
`define SRW_SRC_P33        3'h4
`define SRW_SRC_P27        3'h5
`define SRW_SRC_NOR_LO     3'h6
`define SRW_SRC_NOR_ALL    3'h7

// Source codes of the second recovery register.
`define SRW_SRC2_NAND_LO   3'h2
`define SRW_SRC2_NAND_ALL  3'h3

// Clock rate and derived counts.
`define SRW_CLK_MHZ        32'h0000_0032
`define SRW_T_POR_US       32'h0000_03E8
`define SRW_T_POR_CYC      (`SRW_T_POR_US * `SRW_CLK_MHZ)
`define SRW_WIN_PROC_CYC   32'h0000_003C
`define SRW_XTAL_PER_PROC  32'h0000_0002
`define SRW_WIN_CYC        (`SRW_WIN_PROC_CYC * `SRW_XTAL_PER_PROC)
`define SRW_T_RC_NS        32'h0000_0190
`define SRW_RC_DIV         ((`SRW_T_RC_NS * `SRW_CLK_MHZ) / 32'h0000_03E8)

// Watchdog tap limits in oscillator ticks.
`define SRW_WDT_TAP0       16'h0100
`define SRW_WDT_TAP1       16'h0200
`define SRW_WDT_TAP2       16'h0400
`define SRW_WDT_TAP3       16'h1000

// Condition flags reported after a watchdog instruction, as z, s, v.
`define SRW_WDT_FLAGS      3'h0

`endif

// >>> rtl/srw_pkg.sv
// Types of the stop recovery and watchdog block.
package srw_pkg;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_STOP} srw_state_e;

  typedef struct packed {
    logic       cold_warm;
    logic       level_high;
    logic       por_delay;
    logic [2:0] src;
    logic [1:0] rsvd;
  } srw_smr_s;

  typedef struct packed {
    logic       rsvd7;
    logic       xor_high;
    logic       rsvd5;
    logic [2:0] src;
    logic [1:0] rsvd;
  } srw_stop_wake_config_second_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       stop_run;
    logic       halt_run;
    logic [1:0] tap;
  } srw_watchdog_mode_config_s;

endpackage

// >>> rtl/srw_wdog.sv
// Retriggerable watchdog counter ticked by the internal oscillator divider.
`timescale 1ns/100ps
`default_nettype none
`include "srw_map.svh"
module srw_wdog (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       kick,
  input  wire logic       run,
  input  wire logic [1:0] tap,
  output logic            armed,
  output logic            timeout
);

  // The divider has no reset, so it starts from a known phase instead of sitting at unknown.
  logic [15:0] rc_div = 16'h0000;
  logic [15:0] cnt;
  logic [15:0] next_rc_div;
  logic [15:0] next_cnt;
  logic        next_armed;
  logic        next_timeout;
  logic        rc_tick;

  function automatic logic [15:0] tap_limit(input logic [1:0] sel);
    unique case (sel)
      2'h0: tap_limit = `SRW_WDT_TAP0;
      2'h1: tap_limit = `SRW_WDT_TAP1;
      2'h2: tap_limit = `SRW_WDT_TAP2;
      2'h3: tap_limit = `SRW_WDT_TAP3;
    endcase
  endfunction

  always_comb begin
    // Oscillator tick divider.
    // The oscillator runs free of the core reset, so it is not held in reset by the core.
    rc_tick      = (rc_div == 16'(`SRW_RC_DIV - 32'h1));
    next_rc_div  = rc_tick ? 16'h0000 : rc_div + 16'h0001;
    next_armed   = armed;
    next_cnt     = cnt;
    next_timeout = 1'b0;
    if (kick) begin
      next_armed = 1'b1;
      next_cnt   = 16'h0000;
    end else if (armed && run && rc_tick) begin
      if (cnt == tap_limit(tap) - 16'h0001) begin
        next_timeout = 1'b1;
        next_cnt     = 16'h0000;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    rc_div <= next_rc_div;
    if (reset) begin
      armed   <= 1'b0;
      cnt     <= 16'h0000;
      timeout <= 1'b0;
    end else begin
      armed   <= next_armed;
      cnt     <= next_cnt;
      timeout <= next_timeout;
    end
  end

  property p_idle_until_armed;
    @(posedge clk) disable iff (reset) !armed |=> !timeout;
  endproperty
  a_idle_until_armed: assert property (p_idle_until_armed) else $error("Timeout while unarmed.");

  property p_kick_restarts;
    @(posedge clk) disable iff (reset) kick |=> (cnt == 16'h0000) && armed && !timeout;
  endproperty
  a_kick_restarts: assert property (p_kick_restarts) else $error("Kick did not restart count.");

endmodule
`default_nettype wire

// >>> rtl/srw_top.sv
// Stop mode recovery control, watchdog mode register and reset sequencing with APB access.
// Notes on behaviour
// - Delay bit one inserts power-on delay.
// - Level bit picks high or low wake.
// - Read-only bit shows warm start.
// - Either recovery register source wakes device.
// - Output-configured pins never join wake logic.
// - Second recovery register bits are write-only.
// - Watchdog is retriggerable one-shot resetting core.
// - Watchdog starts on first instruction, refreshes later.
// - Watchdog instruction updates zero, sign, overflow.
// - Watchdog runs from internal oscillator.
// - Mode low bits choose timeout tap.
// - Bits two, three: halt, stop run.
// - Mode writes only within 120-clock window.
// - Later mode writes are ignored.
// - Mode register reads back zero.
// - Mode register sits at index 0Fh.
// - Three-bit field picks first recovery source.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "srw_map.svh"
module srw_top #(
  parameter int unsigned POR_DELAY_CYCLES = `SRW_T_POR_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  P2_IN,
  input  wire logic [7:0]  P2_IS_OUT,
  input  wire logic [2:0]  P3_IN,
  input  wire logic        STOP_REQ,
  input  wire logic        HALT_ACTIVE,
  input  wire logic        EXT_RESET,
  input  wire logic        WDT_INSN,
  output logic             CPU_RESET,
  output logic             IN_STOP,
  output logic             FLAG_WE,
  output logic      [2:0]  FLAG_ZSV
);

  srw_pkg::srw_state_e state;
  srw_pkg::srw_state_e next_state;
  srw_pkg::srw_smr_s   stop_wake_config_first;
  srw_pkg::srw_smr_s   next_smr;
  srw_pkg::srw_stop_wake_config_second_s  stop_wake_config_second;
  srw_pkg::srw_stop_wake_config_second_s  next_stop_wake_config_second;
  srw_pkg::srw_watchdog_mode_config_s watchdog_mode_config;
  srw_pkg::srw_watchdog_mode_config_s next_watchdog_mode_config;
  logic [31:0] rst_cnt;
  logic [31:0] next_rst_cnt;
  logic [7:0]  win_cnt;
  logic [7:0]  next_win_cnt;
  logic        next_cpu_reset;
  logic        next_in_stop;
  logic        next_flag_we;
  logic [2:0]  next_flag_zsv;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wdt_armed;
  logic        wdt_timeout;
  logic        wdt_run;
  logic        wdt_reset;
  logic        acc;
  logic        wr_now;
  logic        win_open;
  logic [1:0]  src1;
  logic [1:0]  src2;
  logic        smr_hit;
  logic        stop_wake_config_second_hit;
  logic        wake_hit;

  function automatic logic hits(input logic [9:0] addr, input logic [7:0] idx);
    hits = (addr == {idx, 2'b00});
  endfunction

  // Gate results are {valid, value}; a gate with no input pin left never wakes.
  function automatic logic [1:0] nor_gate(input logic [7:0] pins, input logic [7:0] use_mask);
    nor_gate = {|use_mask, ~|(pins & use_mask)};
  endfunction

  function automatic logic [1:0] nand_gate(input logic [7:0] pins, input logic [7:0] use_mask);
    nand_gate = {|use_mask, ~&(pins | ~use_mask)};
  endfunction

  srw_wdog u_wdog (
    .clk     (CLK),
    .reset   (wdt_reset),
    .kick    (WDT_INSN),
    .run     (wdt_run),
    .tap     (watchdog_mode_config.tap),
    .armed   (wdt_armed),
    .timeout (wdt_timeout)
  );

  assign wdt_reset = RESET || CPU_RESET;

  assign wdt_run = ((state == srw_pkg::ST_RUN) && (!HALT_ACTIVE || watchdog_mode_config.halt_run))
                || ((state == srw_pkg::ST_STOP) && watchdog_mode_config.stop_run);

  always_comb begin
    unique case (stop_wake_config_first.src)
      `SRW_SRC_P31:     src1 = {1'b1, P3_IN[0]};
      `SRW_SRC_P32:     src1 = {1'b1, P3_IN[1]};
      `SRW_SRC_P33:     src1 = {1'b1, P3_IN[2]};
      `SRW_SRC_P27:     src1 = {!P2_IS_OUT[7], P2_IN[7]};
      `SRW_SRC_NOR_LO:  src1 = nor_gate(P2_IN, 8'h0F & ~P2_IS_OUT);
      `SRW_SRC_NOR_ALL: src1 = nor_gate(P2_IN, ~P2_IS_OUT);
      default:          src1 = 2'b00;
    endcase
    unique case (stop_wake_config_second.src)
      `SRW_SRC2_NAND_LO:  src2 = nand_gate(P2_IN, 8'h0F & ~P2_IS_OUT);
      `SRW_SRC2_NAND_ALL: src2 = nand_gate(P2_IN, ~P2_IS_OUT);
      default:            src2 = 2'b00;
    endcase
    smr_hit  = src1[1] && (src1[0] == stop_wake_config_first.level_high);
    stop_wake_config_second_hit = src2[1] && ((src2[0] ^ stop_wake_config_second.xor_high) == stop_wake_config_first.level_high);
    wake_hit = smr_hit || stop_wake_config_second_hit;
  end

  assign acc      = PSEL && PENABLE;
  assign wr_now   = acc && PREADY && PWRITE;
  assign win_open = (state == srw_pkg::ST_RUN) && (win_cnt < 8'(`SRW_WIN_CYC));

  always_comb begin
    next_state    = state;
    next_rst_cnt  = rst_cnt;
    next_win_cnt  = win_cnt;
    next_smr      = stop_wake_config_first;
    next_stop_wake_config_second     = stop_wake_config_second;
    next_watchdog_mode_config    = watchdog_mode_config;
    next_flag_zsv = FLAG_ZSV;
    next_flag_we  = WDT_INSN && (state == srw_pkg::ST_RUN);
    if (next_flag_we) begin
      next_flag_zsv = `SRW_WDT_FLAGS;
    end
    unique case (state)
      srw_pkg::ST_RESET: begin
        if (rst_cnt == 32'h0000_0000) begin
          next_state   = srw_pkg::ST_RUN;
          next_win_cnt = 8'h00;
        end else begin
          next_rst_cnt = rst_cnt - 32'h0000_0001;
        end
      end
      srw_pkg::ST_RUN: begin
        if (win_open) begin
          next_win_cnt = win_cnt + 8'h01;
        end
        if (STOP_REQ) begin
          next_state = srw_pkg::ST_STOP;
        end
      end
      srw_pkg::ST_STOP: begin
        if (wake_hit) begin
          next_smr.cold_warm = 1'b1;
          if (stop_wake_config_first.por_delay) begin
            next_state   = srw_pkg::ST_RESET;
            next_rst_cnt = 32'(POR_DELAY_CYCLES - 32'h1);
          end else begin
            next_state   = srw_pkg::ST_RUN;
            next_win_cnt = 8'h00;
          end
        end
      end
    endcase
    if (wr_now && hits(PADDR, `SRW_IDX_SMR)) begin
      next_smr.level_high = PWDATA[6];
      next_smr.por_delay  = PWDATA[5];
      next_smr.src        = PWDATA[4:2];
    end
    if (wr_now && hits(PADDR, `SRW_IDX_STOP_WAKE_CONFIG_SECOND)) begin
      next_stop_wake_config_second.xor_high = PWDATA[6];
      next_stop_wake_config_second.src      = PWDATA[4:2];
    end
    if (wr_now && hits(PADDR, `SRW_IDX_WATCHDOG_MODE_CONFIG) && win_open) begin
      next_watchdog_mode_config.stop_run = PWDATA[3];
      next_watchdog_mode_config.halt_run = PWDATA[2];
      next_watchdog_mode_config.tap      = PWDATA[1:0];
    end
    if (EXT_RESET || wdt_timeout) begin
      next_state         = srw_pkg::ST_RESET;
      next_rst_cnt       = 32'(POR_DELAY_CYCLES - 32'h1);
      next_smr.cold_warm = 1'b0;
    end
    next_cpu_reset = (next_state == srw_pkg::ST_RESET);
    next_in_stop   = (next_state == srw_pkg::ST_STOP);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state     <= srw_pkg::ST_RESET;
      rst_cnt   <= 32'(POR_DELAY_CYCLES - 32'h1);
      win_cnt   <= 8'h00;
      stop_wake_config_first       <= `SRW_SMR_RST;
      stop_wake_config_second      <= `SRW_STOP_WAKE_CONFIG_SECOND_RST;
      watchdog_mode_config     <= `SRW_WATCHDOG_MODE_CONFIG_RST;
      CPU_RESET <= 1'b1;
      IN_STOP   <= 1'b0;
      FLAG_WE   <= 1'b0;
      FLAG_ZSV  <= 3'h0;
    end else begin
      state     <= next_state;
      rst_cnt   <= next_rst_cnt;
      win_cnt   <= next_win_cnt;
      stop_wake_config_first       <= next_smr;
      stop_wake_config_second      <= next_stop_wake_config_second;
      watchdog_mode_config     <= next_watchdog_mode_config;
      CPU_RESET <= next_cpu_reset;
      IN_STOP   <= next_in_stop;
      FLAG_WE   <= next_flag_we;
      FLAG_ZSV  <= next_flag_zsv;
    end
  end

  // One wait state keeps every APB output a flip-flop at the cost of a cycle per access.
  always_comb begin
    next_pready  = acc && !PREADY;
    next_pslverr = 1'b0;
    next_prdata  = PRDATA;
    if (acc && !PREADY) begin
      next_pslverr = !(hits(PADDR, `SRW_IDX_SMR) || hits(PADDR, `SRW_IDX_STOP_WAKE_CONFIG_SECOND)
                    || hits(PADDR, `SRW_IDX_WATCHDOG_MODE_CONFIG));
      if (!PWRITE && hits(PADDR, `SRW_IDX_SMR)) begin
        next_prdata = {24'h000000, stop_wake_config_first.cold_warm, stop_wake_config_first.level_high, stop_wake_config_first.por_delay, stop_wake_config_first.src, 2'b00};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  sequence s_stop_wake;
    (state == srw_pkg::ST_STOP) && wake_hit && !EXT_RESET && !wdt_timeout;
  endsequence

  property p_fast_wake;
    @(posedge CLK) disable iff (RESET)
      s_stop_wake ##0 !stop_wake_config_first.por_delay |=> (state == srw_pkg::ST_RUN) && !CPU_RESET && !IN_STOP;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("Fast wake did not resume.");

  property p_delayed_wake;
    @(posedge CLK) disable iff (RESET)
      s_stop_wake ##0 stop_wake_config_first.por_delay |=> CPU_RESET ##1 CPU_RESET;
  endproperty
  a_delayed_wake: assert property (p_delayed_wake) else $error("Delay not inserted.");

  property p_warm_flag;
    @(posedge CLK) disable iff (RESET) s_stop_wake |=> stop_wake_config_first.cold_warm;
  endproperty
  a_warm_flag: assert property (p_warm_flag) else $error("Warm start not flagged.");

  property p_cold_flag;
    @(posedge CLK) disable iff (RESET) (EXT_RESET || wdt_timeout) |=> !stop_wake_config_first.cold_warm && CPU_RESET;
  endproperty
  a_cold_flag: assert property (p_cold_flag) else $error("Reset not cold or no reset.");

  property p_second_source;
    @(posedge CLK) disable iff (RESET)
      (state == srw_pkg::ST_STOP) && stop_wake_config_second_hit && !EXT_RESET |=> !IN_STOP;
  endproperty
  a_second_source: assert property (p_second_source) else $error("Second source ignored.");

  property p_late_write;
    @(posedge CLK) disable iff (RESET)
      wr_now && hits(PADDR, `SRW_IDX_WATCHDOG_MODE_CONFIG) && !win_open |=> $stable(watchdog_mode_config);
  endproperty
  a_late_write: assert property (p_late_write) else $error("Mode changed after window.");

  property p_window_write;
    @(posedge CLK) disable iff (RESET)
      wr_now && hits(PADDR, `SRW_IDX_WATCHDOG_MODE_CONFIG) && win_open |=> watchdog_mode_config[3:0] == $past(PWDATA[3:0]);
  endproperty
  a_window_write: assert property (p_window_write) else $error("Mode write lost.");

  property p_mode_unreadable;
    @(posedge CLK) disable iff (RESET)
      acc && !PREADY && !PWRITE && hits(PADDR, `SRW_IDX_WATCHDOG_MODE_CONFIG) |=> PREADY && (PRDATA == 32'h0);
  endproperty
  a_mode_unreadable: assert property (p_mode_unreadable) else $error("Mode readable.");

endmodule
`default_nettype wire

// >>> tb/srw_core_model.sv
// Behavioural model of the processor core and the wake-up pins around the block.
`timescale 1ns/100ps
`default_nettype none
module srw_core_model (
  output logic       clk,
  output logic [7:0] p2_in,
  output logic [7:0] p2_is_out,
  output logic [2:0] p3_in,
  output logic       stop_req,
  output logic       halt_active,
  output logic       ext_reset,
  output logic       wdt_insn
);
  initial begin
    clk = 1'b0;
    p2_in = 8'h00;
    p2_is_out = 8'h00;
    p3_in = 3'h0;
    stop_req = 1'b0;
    halt_active = 1'b0;
    ext_reset = 1'b0;
    wdt_insn = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic pulse_stop();
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
  endtask

  task automatic kick();
    @(posedge clk);
    wdt_insn <= 1'b1;
    @(posedge clk);
    wdt_insn <= 1'b0;
  endtask

  task automatic set_halt(input logic h);
    @(posedge clk);
    halt_active <= h;
  endtask

  task automatic pulse_ext();
    @(posedge clk);
    ext_reset <= 1'b1;
    @(posedge clk);
    ext_reset <= 1'b0;
  endtask

  task automatic drive_pins(input logic [7:0] out, input logic [7:0] p2, input logic [2:0] p3);
    @(posedge clk);
    p2_is_out <= out;
    p2_in <= p2;
    p3_in <= p3;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/stop_recovery_and_watchdog_tb_top.sv
// Self-checking bench of the stop recovery and watchdog block.
`timescale 1ns/100ps
`default_nettype none
`include "srw_map.svh"
module stop_recovery_and_watchdog_tb_top;
  localparam logic [9:0] SMR_A = {`SRW_IDX_SMR, 2'b00};
  localparam logic [9:0] STOP_WAKE_CONFIG_SECOND_A = {`SRW_IDX_STOP_WAKE_CONFIG_SECOND, 2'b00};
  localparam logic [9:0] WDT_A = {`SRW_IDX_WATCHDOG_MODE_CONFIG, 2'b00};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  p2_in, p2_is_out;
  logic [2:0]  p3_in, flag_zsv;
  logic        stop_req, halt_active, ext_reset, wdt_insn, cpu_reset, in_stop, flag_we;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  srw_core_model core (.clk(clk), .p2_in(p2_in), .p2_is_out(p2_is_out), .p3_in(p3_in),
    .stop_req(stop_req), .halt_active(halt_active), .ext_reset(ext_reset), .wdt_insn(wdt_insn));

  srw_top #(.POR_DELAY_CYCLES(8)) u_dut (.CLK(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .P2_IN(p2_in), .P2_IS_OUT(p2_is_out), .P3_IN(p3_in),
    .STOP_REQ(stop_req), .HALT_ACTIVE(halt_active), .EXT_RESET(ext_reset),
    .WDT_INSN(wdt_insn), .CPU_RESET(cpu_reset), .IN_STOP(in_stop), .FLAG_WE(flag_we),
    .FLAG_ZSV(flag_zsv));

  task automatic wrap_up();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, {24'h0, d}, rd, err);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, {24'h0, exp});
    chk(32'(err), 32'(exp_err));
  endtask

  task automatic wait_cpu(input logic lvl);
    int n;
    n = 0;
    while (cpu_reset !== lvl && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(cpu_reset), 32'(lvl));
  endtask

  task automatic t_regs();
    rd_chk(SMR_A, 8'h20, 1'b0);
    rd_chk(STOP_WAKE_CONFIG_SECOND_A, 8'h00, 1'b0);
    rd_chk(WDT_A, 8'h00, 1'b0);
    rd_chk(10'h100, 8'h00, 1'b1);
  endtask

  task automatic t_window();
    int hit;
    hit = 0;
    wait_cpu(1'b0);
    wr(WDT_A, 8'h00);
    repeat (130) @(posedge clk);
    wr(WDT_A, 8'h03);
    repeat (6000) begin
      @(posedge clk);
      if (cpu_reset !== 1'b0) hit = 1;
    end
    chk(32'(hit), 32'h0);
  endtask

  task automatic t_wdog(input int ticks);
    int n;
    core.kick();
    #1 chk({28'h0, flag_we, flag_zsv}, 32'h8);
    repeat (3000) @(posedge clk);
    core.kick();
    n = 0;
    while (cpu_reset !== 1'b1 && n < ticks * 20 + 200) begin
      @(posedge clk);
      n++;
    end
    checks_done++;
    if (n < ticks * 20 - 40 || n > ticks * 20 + 40) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, ticks * 20);
    end
  endtask

  task automatic t_wake(input logic [7:0] stop_wake_config_first, input logic [7:0] stop_wake_config_second, input logic [7:0] out,
                        input logic [7:0] idle2, input logic [7:0] act2, input logic [2:0] act3,
                        input logic dly);
    wr(STOP_WAKE_CONFIG_SECOND_A, stop_wake_config_second);
    wr(SMR_A, stop_wake_config_first);
    core.drive_pins(out, idle2, 3'h0);
    core.pulse_stop();
    repeat (10) @(posedge clk);
    chk(32'(in_stop), 32'h1);
    core.drive_pins(out, act2, act3);
    chk(32'(in_stop), 32'h0);
    chk(32'(cpu_reset), 32'(dly));
    wait_cpu(1'b0);
    rd_chk(SMR_A, stop_wake_config_first | 8'h80, 1'b0);
  endtask

  task automatic t_halt();
    int hit;
    hit = 0;
    core.kick();
    core.set_halt(1'b1);
    repeat (11000) begin
      @(posedge clk);
      if (cpu_reset !== 1'b0) hit = 1;
    end
    chk(32'(hit), 32'h0);
    core.set_halt(1'b0);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_window();
    t_wdog(256);
    rd_chk(SMR_A, 8'h20, 1'b0);
    wait_cpu(1'b0);
    wr(WDT_A, 8'h01);
    rd_chk(WDT_A, 8'h00, 1'b0);
    t_wdog(512);
    wait_cpu(1'b0);
    t_wake(8'h48, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 1'b0);
    t_wake(8'h68, 8'h00, 8'h00, 8'h00, 8'h00, 3'h1, 1'b1);
    t_wake(8'h18, 8'h00, 8'h01, 8'h01, 8'h03, 3'h0, 1'b0);
    t_wake(8'h40, 8'h08, 8'h00, 8'h0F, 8'h0B, 3'h0, 1'b0);
    rd_chk(STOP_WAKE_CONFIG_SECOND_A, 8'h00, 1'b0);
    t_halt();
    core.pulse_ext();
    wait_cpu(1'b1);
    wait_cpu(1'b0);
    rd_chk(SMR_A, 8'h40, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
